// ===== pcm_channel.sv
// Per-channel mode control: speed, loopbacks, reset, powerdown, LEDs.
// Assumes all inputs synchronous to i_clk_sys; register port is indexed.
`timescale 1ns/1ps
module pcm_channel
    import pcm_pkg::*;
#(
    parameter int         READY   = READY_CYC,
    parameter int         STRETCH = STRETCH_CYC,
    parameter logic [1:0] CHANNEL = 2'h0
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_b,
    input  wire logic        i_reset_pin_b,
    input  wire logic [4:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    input  wire logic        i_aneg_pin,
    input  wire logic        i_speed_pin,
    input  wire logic        i_aneg_speed_100,
    input  wire logic        i_aneg_full,
    input  wire logic        i_link_pass,
    input  wire logic        i_collision,
    input  wire logic        i_jabber,
    input  wire logic        i_activity,
    input  wire logic        i_rmii_sel,
    input  wire logic        i_symbol_bypass_interface,
    input  wire logic        i_fiber_mode,
    input  wire logic        i_far_end_fault,
    input  wire logic        i_repeater_pin,
    input  wire logic        i_led_set_strap_pin,
    input  wire logic [2:0]  i_mgmt_addr_straps,
    input  wire logic        i_txen,
    input  wire logic [3:0]  i_txd,
    input  wire logic        i_line_crs,
    input  wire logic        i_line_rxdv,
    input  wire logic [3:0]  i_line_rxd,
    output logic             o_crs,
    output logic             o_rxdv,
    output logic      [3:0]  o_rxd,
    output logic             o_tp_tx_en,
    output logic             o_tp_rx_en,
    output logic             o_link_pulse_en,
    output logic             o_speed_100,
    output logic             o_full_duplex,
    output logic      [3:0]  o_led_outputs,
    output logic      [4:0]  o_mgmt_addr,
    output logic             o_int_reset,
    output logic             o_ready
);

    // ==========================================================
    // Register state
    logic [15:0] ctrl;
    logic [2:0]  led_def;
    logic        crs_dis;
    logic [2:0]  addr_latch;
    pcm_rst_state_type rst_state;
    logic        in_reset;
    logic        pd;
    logic        sw_rst;
    logic        act_str;
    logic        col_str;

    assign in_reset = (rst_state == RS_PULSE) || (rst_state == RS_HOLD);
    assign pd       = ctrl[CTRL_PDOWN];
    assign sw_rst   = i_wr && (i_addr == REG_CTRL) && i_wdata[CTRL_RESET];

    function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
        return a == r;
    endfunction : hit

    // ==========================================================
    // Reset sequencing and LED stretchers
    pcm_rstseq #(
        .READY (READY),
        .PULSE (RST_PULSE_CYC)
    ) u_rstseq (
        .i_clk_sys   (i_clk_sys),
        .i_rst_b     (i_rst_b),
        .i_sw_rst    (sw_rst),
        .i_pin_rst_b (i_reset_pin_b),
        .i_pd        (pd),
        .o_state     (rst_state)
    );

    pcm_stretch #(.CYC(STRETCH)) u_act (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_clr     (in_reset || pd),
        .i_event   (i_activity),
        .o_active  (act_str)
    );

    pcm_stretch #(.CYC(STRETCH)) u_col (
        .i_clk_sys (i_clk_sys),
        .i_rst_b   (i_rst_b),
        .i_clr     (in_reset || pd),
        .i_event   (i_collision),
        .o_active  (col_str)
    );

    // ==========================================================
    // Software registers; every reset source restores defaults
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b || in_reset) begin
            ctrl    <= CTRL_RESET_VAL;
            crs_dis <= 1'b0;
        end else if (i_wr && hit(i_addr, REG_CTRL)) begin
            ctrl <= i_wdata;
        end else if (i_wr && hit(i_addr, REG_CHCFG)) begin
            crs_dis <= i_wdata[CHCFG_CRS_DIS];
        end
    end

    // Strap forces the LED set; otherwise the field is writable
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b || in_reset || i_led_set_strap_pin) begin
            led_def <= i_led_set_strap_pin ? LED_DEF_SET1
                                           : LED_DEF_DEFAULT;
        end else if (i_wr && hit(i_addr, REG_GCFG)) begin
            led_def <= i_wdata[GCFG_LED_HI:GCFG_LED_LO];
        end
    end

    // Address straps are caught while the internal reset is active
    always_ff @(posedge i_clk_sys) begin
        if (in_reset) begin
            addr_latch <= i_mgmt_addr_straps;
        end
        o_mgmt_addr <= {addr_latch, CHANNEL};
    end

    // ==========================================================
    // Mode resolution
    logic aneg_on;
    logic spd100;
    logic full_duplex_ind;
    logic diag;
    logic active;
    logic reflect_ok;

    assign aneg_on = ctrl[CTRL_ANEG] && i_aneg_pin;
    // The speed strap is only a board-level copy of the bit here
    assign spd100  = aneg_on ? i_aneg_speed_100 : ctrl[CTRL_SPEED];
    assign full_duplex_ind     = aneg_on ? i_aneg_full : ctrl[CTRL_DUPLEX];
    assign diag    = ctrl[CTRL_LOOP] && !i_symbol_bypass_interface;
    assign active  = !in_reset && !pd;
    assign reflect_ok = !i_collision && !full_duplex_ind && i_link_pass
                     && !i_rmii_sel
                     && !(!spd100 && i_jabber)
                     && !crs_dis
                     && !i_repeater_pin;

    // ==========================================================
    // Receive-side datapath and line enables
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b || !active) begin
            o_crs  <= 1'b0;
            o_rxdv <= 1'b0;
            o_rxd  <= 4'h0;
        end else if (diag) begin
            o_crs  <= i_txen;
            o_rxdv <= i_txen;
            o_rxd  <= i_txd;
        end else begin
            o_crs  <= i_line_crs || (reflect_ok && i_txen);
            o_rxdv <= i_line_rxdv;
            o_rxd  <= i_line_rxd;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_tp_tx_en      <= 1'b0;
            o_tp_rx_en      <= 1'b0;
            o_link_pulse_en <= 1'b0;
        end else begin
            o_tp_tx_en      <= active && !diag;
            o_tp_rx_en      <= active && !diag;
            o_link_pulse_en <= active && !diag;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_speed_100   <= 1'b0;
            o_full_duplex <= 1'b0;
            o_int_reset   <= 1'b1;
            o_ready       <= 1'b0;
        end else begin
            o_speed_100   <= spd100;
            o_full_duplex <= full_duplex_ind;
            o_int_reset   <= in_reset;
            o_ready       <= (rst_state == RS_RUN);
        end
    end

    // ==========================================================
    // LEDs, active low
    logic set1;
    assign set1 = (led_def == LED_DEF_SET1);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b || !active) begin
            o_led_outputs <= 4'hf;
        end else if (set1) begin
            o_led_outputs[3] <= !(i_link_pass && !act_str);
            o_led_outputs[2] <= !col_str;
            o_led_outputs[1] <= !(full_duplex_ind && i_link_pass);
            o_led_outputs[0] <= i_fiber_mode ? !i_far_end_fault
                                             : !spd100;
        end else begin
            o_led_outputs[3] <= !(i_link_pass && spd100);
            o_led_outputs[2] <= !act_str;
            o_led_outputs[1] <= !(full_duplex_ind && i_link_pass);
            o_led_outputs[0] <= i_fiber_mode ? !i_far_end_fault
                                             : !(i_link_pass && !spd100);
        end
    end

    // ==========================================================
    // Register read port, data one cycle after the strobe
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b || !i_rd) begin
            o_rdata <= 16'h0000;
        end else begin
            case (i_addr)
                REG_CTRL: begin
                    o_rdata <= {in_reset, ctrl[14:0]};
                end
                REG_GCFG: begin
                    o_rdata <= 16'({led_def, 11'h000});
                end
                REG_STATUS: begin
                    o_rdata <= 16'({addr_latch, CHANNEL, (rst_state == RS_RUN),
                                    diag, i_jabber, i_link_pass, full_duplex_ind,
                                    spd100});
                end
                REG_CHCFG: begin
                    o_rdata <= {15'h0000, crs_dis};
                end
                default: begin
                    o_rdata <= 16'h0000;
                end
            endcase
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    sequence s_sw_reset;
        i_wr && (i_addr == REG_CTRL) && i_wdata[CTRL_RESET] && i_reset_pin_b;
    endsequence

    sequence s_pulse_done;
        o_int_reset [*8] ##[1:20] !o_int_reset;
    endsequence

    sequence s_col_seen;
        active && set1 && i_collision ##1 active && set1;
    endsequence

    // Cycles since the last reset request or powerdown; ready must follow
    // within the ready time plus the few cycles of output registering
    logic [31:0] since_rst;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b || sw_rst || !i_reset_pin_b || pd) begin
            since_rst <= 32'h0000_0000;
        end else if (since_rst != 32'hffff_ffff) begin
            since_rst <= since_rst + 32'h0000_0001;
        end
    end

    a_speed_aneg: assert property (aneg_on |=> o_speed_100 == $past(i_aneg_speed_100))
        else $error("speed not taken from negotiation");
    a_status_speed: assert property (i_rd && i_addr == REG_STATUS |=> o_rdata[ST_SPEED] == $past(spd100))
        else $error("status speed bit wrong");
    a_led_speed: assert property (active && set1 && !i_fiber_mode |=> o_led_outputs[0] == !$past(spd100))
        else $error("speed LED wrong");
    a_crs_reflect: assert property (active && !diag && reflect_ok && i_txen |=> o_crs)
        else $error("carrier not reflected");
    a_crs_blocked: assert property (active && !diag && !i_line_crs && (i_collision || i_rmii_sel || !i_link_pass) |=> !o_crs)
        else $error("carrier reflected when blocked");
    a_crs_jabber: assert property (active && !diag && !i_line_crs && !spd100 && i_jabber |=> !o_crs)
        else $error("carrier reflected in jabber");
    a_crs_cfg_off: assert property (active && !diag && !i_line_crs && (crs_dis || i_repeater_pin) |=> !o_crs)
        else $error("carrier reflected while disabled");
    a_diag_path: assert property (active && diag |=> o_rxd == $past(i_txd) && o_crs == $past(i_txen) && !o_tp_tx_en)
        else $error("diagnostic loopback path wrong");
    a_bypass_refuse: assert property (
        active && i_symbol_bypass_interface |=> o_tp_rx_en)
        else $error("loopback entered under bypass");
    // The reset output lags the sequencer by a register, hence two edges
    a_sw_reset_seq: assert property (s_sw_reset |-> ##2 s_pulse_done)
        else $error("register reset sequence wrong");
    a_reset_clears: assert property ($fell(o_int_reset) |-> ctrl == CTRL_RESET_VAL)
        else $error("reset did not restore defaults");
    a_pin_hold: assert property (!i_reset_pin_b |-> ##2 o_int_reset)
        else $error("pin reset not held");
    a_pd_line: assert property (pd |=> !o_tp_tx_en && o_led_outputs == 4'hf)
        else $error("powerdown left line active");
    a_led_strap: assert property (i_led_set_strap_pin |=> led_def == LED_DEF_SET1)
        else $error("LED set strap not forced");
    a_addr_low: assert property (o_mgmt_addr[1:0] == CHANNEL)
        else $error("address low bits not channel");
    a_diag_line: assert property (active && diag |=>
        !o_tp_rx_en && !o_link_pulse_en)
        else $error("line path left on in loopback");
    a_pd_datapath: assert property (pd |=>
        !o_crs && !o_rxdv && !o_link_pulse_en)
        else $error("datapath active in powerdown");
    a_rst_bit_clear: assert property (
        i_rd && i_addr == REG_CTRL && !in_reset |=> !o_rdata[CTRL_RESET])
        else $error("reset bit did not clear");
    a_col_stretch: assert property (s_col_seen |=> !o_led_outputs[2])
        else $error("collision LED not lit");
    a_ready_time: assert property (
        since_rst == 32'(READY + 4) |-> o_ready)
        else $error("not ready in time");

endmodule : pcm_channel

// ===== pcm_pkg.sv
// Constants shared by the per-channel mode and housekeeping logic.
// Assumes a 100 MHz system clock; register bus carries register indices.
package pcm_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_KHZ       = 100_000;
    localparam int READY_TIME_MS = 50;
    localparam int READY_CYC     = READY_TIME_MS * CLK_KHZ;
    localparam int STRETCH_MS    = 100;
    localparam int STRETCH_CYC   = STRETCH_MS * CLK_KHZ;
    localparam int RST_PULSE_CYC = 16;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [4:0] REG_CTRL   = 5'h00;
    localparam logic [4:0] REG_GCFG   = 5'h10;
    localparam logic [4:0] REG_STATUS = 5'h12;
    localparam logic [4:0] REG_CHCFG  = 5'h13;

    // ==========================================================
    // Control register fields
    localparam int CTRL_RESET  = 15;
    localparam int CTRL_LOOP   = 14;
    localparam int CTRL_SPEED  = 13;
    localparam int CTRL_ANEG   = 12;
    localparam int CTRL_PDOWN  = 11;
    localparam int CTRL_DUPLEX = 8;
    localparam logic [15:0] CTRL_RESET_VAL = 16'h3100;

    // Global configuration: LED definition field
    localparam int GCFG_LED_LO = 11;
    localparam int GCFG_LED_HI = 13;
    localparam logic [2:0] LED_DEF_DEFAULT = 3'h0;
    localparam logic [2:0] LED_DEF_SET1    = 3'h1;

    // Channel configuration: carrier loopback disable
    localparam int CHCFG_CRS_DIS = 0;

    // Status output fields
    localparam int ST_SPEED  = 0;
    localparam int ST_DUPLEX = 1;
    localparam int ST_LINK   = 2;
    localparam int ST_JABBER = 3;
    localparam int ST_LOOP   = 4;
    localparam int ST_READY  = 5;
    localparam int ST_ADDR_LO = 6;

    // ==========================================================
    // Reset sequencer states
    typedef enum logic [4:0] {
        RS_PULSE = 5'h01,
        RS_HOLD  = 5'h02,
        RS_WAIT  = 5'h04,
        RS_RUN   = 5'h08,
        RS_DOWN  = 5'h10
    } pcm_rst_state_type;

endpackage : pcm_pkg

// ===== pcm_stretch.sv
// Retriggerable pulse stretcher for LED event indications.
// Assumes the event input is synchronous to i_clk_sys.
`timescale 1ns/1ps
module pcm_stretch
    import pcm_pkg::*;
#(
    parameter int CYC = STRETCH_CYC
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    input  wire logic i_clr,
    input  wire logic i_event,
    output logic      o_active
);
    localparam int CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYC);

    logic [CW-1:0] cnt;

    initial begin
        if (CYC < 2) $error("pcm_stretch: CYC must be at least 2");
    end

    // ==========================================================
    // Each new event restarts the full stretch window
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b || i_clr) begin
            cnt      <= '0;
            o_active <= 1'b0;
        end else if (i_event) begin
            cnt      <= LOAD;
            o_active <= 1'b1;
        end else begin
            if (cnt != '0) cnt <= cnt - CW'(1);
            o_active <= (cnt > CW'(1));
        end
    end

endmodule : pcm_stretch

// ===== pcm_rstseq.sv
// Reset and powerdown sequencer: internal reset pulse and ready timing.
// Assumes reset pin and control requests are synchronous levels/pulses.
`timescale 1ns/1ps
module pcm_rstseq
    import pcm_pkg::*;
#(
    parameter int READY = READY_CYC,
    parameter int PULSE = RST_PULSE_CYC
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_b,
    input  wire logic i_sw_rst,
    input  wire logic i_pin_rst_b,
    input  wire logic i_pd,
    output pcm_rst_state_type o_state
);
    localparam int CW = $clog2(READY + 1);
    localparam logic [CW-1:0] PULSE_END = CW'(PULSE - 1);
    localparam logic [CW-1:0] READY_END = CW'(READY - 1);

    logic [CW-1:0] cnt;

    initial begin
        if (PULSE < 1 || READY <= PULSE)
            $error("pcm_rstseq: need 1 <= PULSE < READY");
    end

    // ==========================================================
    // Ready time counts from the start of the reset, pulse included
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_state <= RS_PULSE;
            cnt     <= '0;
        end else if (!i_pin_rst_b) begin
            o_state <= RS_HOLD;
            cnt     <= '0;
        end else if (i_sw_rst) begin
            o_state <= RS_PULSE;
            cnt     <= '0;
        end else begin
            case (o_state)
                RS_PULSE: begin
                    cnt <= cnt + CW'(1);
                    if (cnt == PULSE_END) o_state <= RS_WAIT;
                end
                RS_HOLD: begin
                    o_state <= RS_PULSE;
                    cnt     <= '0;
                end
                RS_WAIT: begin
                    cnt <= cnt + CW'(1);
                    if (i_pd) begin
                        o_state <= RS_DOWN;
                    end else if (cnt == READY_END) begin
                        o_state <= RS_RUN;
                    end
                end
                RS_RUN: begin
                    if (i_pd) o_state <= RS_DOWN;
                end
                RS_DOWN: begin
                    cnt <= '0;
                    if (!i_pd) o_state <= RS_WAIT;
                end
                default: begin
                    o_state <= RS_PULSE;
                    cnt     <= '0;
                end
            endcase
        end
    end

endmodule : pcm_rstseq

// ===== pcm_mac_model.sv
// MAC transmit side model: frames of nibbles with short random gaps.
// Assumes the 100 MHz system clock; outputs move just after rising edges.
`timescale 1ns/1ps
module pcm_mac_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_en,
    output logic            o_txen,
    output logic      [3:0] o_txd
);
    logic [15:0] lf = 16'h5a5a;
    initial o_txen = 1'b0;
    initial o_txd = 4'h0;
    // ==========================================================
    // Frames
    // The nibble keeps moving between frames so stale data never matches
    always @(posedge i_clk_sys) begin
        lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        o_txen <= i_en & (lf[3:0] != 4'h0);
        o_txd <= lf[7:4];
    end
endmodule : pcm_mac_model

// ===== pcm_channel_test.sv
// Self-checking bench for one channel of the mode control block.
// Assumes shortened ready and stretch counts and a MAC model on transmit.
`timescale 1ns/1ps
`define CHK(n, e, s) \
    begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module pcm_channel_test
    import pcm_pkg::*;
();
    localparam int RDY = 200;
    localparam int STR = 20;
    int          samples_checked = 0;
    int          miscompares = 0;
    logic [15:0] seed = 16'h2b8a;
    logic        clk = 1'b0, rst_b = 1'b0, pin_b = 1'b1;
    logic [4:0]  addr = 5'h00, mgmt_addr;
    logic [15:0] wdata = 16'h0000, rdata;
    logic        wr_s = 1'b0, rd_s = 1'b0, spd_pin = 1'b0, an_spd = 1'b0;
    logic        an_pin = 1'b1, an_full = 1'b0;
    logic        col = 1'b0, link = 1'b1, jab = 1'b0, act = 1'b0;
    logic        rmii = 1'b0, byp = 1'b0, fib = 1'b0, fef = 1'b0;
    logic        rep = 1'b0, led_strap = 1'b1, txen, ptx = 1'b0;
    logic [2:0]  straps = 3'h5;
    logic [3:0]  txd, ptd = 4'h0, rxd, leds;
    logic        crs, rxdv, tp_tx, tp_rx, lp_en, spd100, full_duplex_ind, int_rst, ready;

    always #5 clk = ~clk;
    always @(posedge clk) begin
        ptx <= txen;
        ptd <= txd;
    end

    pcm_mac_model pcm_mac_model_i (
        .i_clk_sys(clk), .i_en(1'b1), .o_txen(txen), .o_txd(txd)
    );
    pcm_channel #(.READY(RDY), .STRETCH(STR), .CHANNEL(2'h2)) pcm_channel_i (
        .i_clk_sys(clk), .i_rst_b(rst_b), .i_reset_pin_b(pin_b),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
        .o_rdata(rdata), .i_aneg_pin(an_pin), .i_speed_pin(spd_pin),
        .i_aneg_speed_100(an_spd), .i_aneg_full(an_full), .i_link_pass(link),
        .i_collision(col), .i_jabber(jab), .i_activity(act),
        .i_rmii_sel(rmii), .i_symbol_bypass_interface(byp),
        .i_fiber_mode(fib), .i_far_end_fault(fef), .i_repeater_pin(rep),
        .i_led_set_strap_pin(led_strap), .i_mgmt_addr_straps(straps),
        .i_txen(txen), .i_txd(txd), .i_line_crs(1'b0),
        .i_line_rxdv(1'b0), .i_line_rxd(4'h0), .o_crs(crs),
        .o_rxdv(rxdv), .o_rxd(rxd), .o_tp_tx_en(tp_tx), .o_tp_rx_en(tp_rx),
        .o_link_pulse_en(lp_en), .o_speed_100(spd100), .o_full_duplex(full_duplex_ind),
        .o_led_outputs(leds), .o_mgmt_addr(mgmt_addr),
        .o_int_reset(int_rst), .o_ready(ready)
    );

    // ==========================================================
    // Helpers
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd

    // c: 0 col, 1 fdx, 2 link, 3 rmii, 4 jabber, 5 speed, 6 dis, 7 rep
    function automatic logic crs_exp(input logic t, input logic [7:0] c);
        return t & ~c[0] & ~c[1] & c[2] & ~c[3] & ~(c[4] & ~c[5])
            & ~c[6] & ~c[7];
    endfunction : crs_exp

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        if (a == REG_CTRL) spd_pin <= d[CTRL_SPEED];
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task automatic set_cond(input logic [7:0] c);
        @(posedge clk);
        {rep, jab, rmii, link, col} <= {c[7], c[4], c[3], c[2], c[0]};
    endtask : set_cond

    task automatic wait_ready(input int lim);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        #1 `CHK("ready time", 1'b1, ready)
    endtask : wait_ready

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    initial begin
        repeat (10000) @(posedge clk);
        miscompares++;
        stop_test();
    end

    // ==========================================================
    // Scenarios
    initial begin
        logic [15:0] d;
        logic [7:0]  c;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        wait_ready(RDY + 24);
        `CHK("addr", {straps, 2'h2}, mgmt_addr)
        rd(REG_GCFG, d);
        `CHK("led def1", LED_DEF_SET1, d[13:11])
        for (int k = 0; k < 32; k++) begin
            d = rnd() & rnd() & rnd();
            c = (k < 8) ? 8'h04 ^ (8'h01 << k) : 8'h04 ^ d[7:0];
            if (k == 8) c = 8'h34;
            set_cond(c);
            wr(REG_CTRL, {2'b00, c[5], 4'h0, c[1], 8'h00});
            wr(REG_CHCFG, {15'h0000, c[6]});
            repeat (4) @(negedge clk);
            repeat (8) begin
                @(negedge clk);
                `CHK("crs", crs_exp(ptx, c), crs)
            end
            if (c[2]) `CHK("led_out_zero", ~c[5], leds[0])
            `CHK("led1", ~(c[1] & c[2]), leds[1])
            rd(REG_STATUS, d);
            `CHK("st speed", c[5], d[ST_SPEED])
        end
        set_cond(8'h04);
        wr(REG_CHCFG, 16'h0000);
        // Last pass drops the strap, so the control bits force the mode
        for (int j = 0; j < 3; j++) begin
            @(posedge clk);
            {an_pin, an_spd, an_full} <= {j < 2, j[0], ~j[0]};
            wr(REG_CTRL, {2'b00, ~j[0], 13'h1000});
            repeat (4) @(negedge clk);
            `CHK("aneg spd", (j < 2) ? j[0] : 1'b1, spd100)
            `CHK("aneg fdx", (j < 2) & ~j[0], full_duplex_ind)
        end
        wr(REG_CTRL, 16'h4000);
        repeat (4) @(negedge clk);
        repeat (6) begin
            @(negedge clk);
            `CHK("lb rxd", ptd, rxd)
            `CHK("lb crs", {ptx, ptx}, {crs, rxdv})
            `CHK("lb line", 4'h0, {tp_tx, tp_rx, lp_en, full_duplex_ind})
        end
        wr(REG_CTRL, 16'h0000);
        @(posedge clk);
        byp <= 1'b1;
        wr(REG_CTRL, 16'h4000);
        repeat (4) @(negedge clk);
        `CHK("byp line", 1'b1, tp_rx)
        rd(REG_STATUS, d);
        `CHK("byp lb", 1'b0, d[ST_LOOP])
        @(posedge clk);
        byp <= 1'b0;
        wr(REG_CTRL, 16'h2000);
        for (int j = 0; j < 2; j++) begin
            @(posedge clk);
            {col, act} <= {j[0], ~j[0]};
            @(posedge clk);
            {col, act} <= 2'b00;
            repeat (3) @(negedge clk);
            `CHK("stretch on", ~j[0], leds[3 - j])
            repeat (STR - 5) @(negedge clk);
            `CHK("stretch hold", ~j[0], leds[3 - j])
            repeat (10) @(negedge clk);
            `CHK("stretch end", j[0], leds[3 - j])
        end
        wr(REG_CTRL, 16'h2800);
        repeat (4) @(negedge clk);
        `CHK("pd line", 4'h0, {tp_tx, tp_rx, lp_en, crs})
        rd(REG_CTRL, d);
        `CHK("pd reg", 1'b1, d[CTRL_PDOWN])
        wr(REG_CTRL, 16'h2000);
        @(negedge clk);
        `CHK("pd wake", 1'b0, ready)
        wait_ready(RDY + 4);
        d = rnd();
        @(posedge clk);
        straps <= d[2:0];
        wr(REG_CTRL, 16'h8000);
        repeat (2) @(negedge clk);
        `CHK("sw rst", 1'b1, int_rst)
        wait_ready(RDY + 24);
        `CHK("relatch", {straps, 2'h2}, mgmt_addr)
        rd(REG_CTRL, d);
        `CHK("ctrl dflt", CTRL_RESET_VAL, d)
        @(posedge clk);
        {pin_b, led_strap} <= 2'b00;
        repeat (RDY + 40) @(negedge clk);
        `CHK("pin hold", 2'b10, {int_rst, ready})
        @(posedge clk);
        pin_b <= 1'b1;
        wait_ready(RDY + 24);
        rd(REG_GCFG, d);
        `CHK("led def0", LED_DEF_DEFAULT, d[13:11])
        `CHK("set0 link", 2'b01, {leds[3], leds[0]})
        @(posedge clk);
        {fib, fef} <= 2'b11;
        repeat (4) @(negedge clk);
        `CHK("fiber fef", 1'b0, leds[0])
        wr(5'h1f, 16'hffff);
        rd(5'h1f, d);
        `CHK("unmapped", 16'h0000, d)
        stop_test();
    end
endmodule : pcm_channel_test
